// [verilog/cfd_chan_div.sv]
// Channel select and fractional-N divider word generation
// Operation
// R1: Sixteen channels, numbered zero to fifteen
// R2: One enable bit per channel, two bytes
// R3: Selected channel comes from select register
// R4: All divider words relative to 36 MHz
// R5: Prescaler four; integer and auxiliary counts
// R6: Fraction is 20-bit residual ratio word
// R7: Spacing word is 20-bit ratio word; the code holds a 16-bit spacing word in two bytes
// R8: Spacing separates adjacent channel centres
// R9: Software keeps channels inside lock window
// R10: Software moves base or disables channels
// R11: Divider is base plus channel times spacing
// R12: Base fraction in three bytes, counts nibbles
`timescale 1ns/1ps
`include "cfd_cfg.svh"
module cfd_chan_div #(
    parameter int NUM_CHAN  = `CFD_NUM_CHAN,
    parameter int CHAN_BITS = `CFD_CHAN_BITS,
    parameter int FRAC_BITS = `CFD_FRAC_BITS
) (
    // Clock and reset, 36 MHz reference domain
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    // Register port from the host interface
    input  wire logic [6:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    output logic      [7:0]           reg_rdata,
    // Divider words to the synthesizer
    output logic      [5:0]           div_n,
    output logic      [1:0]           div_a,
    output logic      [FRAC_BITS-1:0] div_frac,
    output logic                      div_update,
    // Selected channel status
    output logic                      chan_enabled
);
    localparam int WORD_BITS = FRAC_BITS + `CFD_INT_BITS;

    // Host registers
    logic [7:0] en_low_r;        // Channel enable, channels 0..7
    logic [7:0] en_high_r;       // Channel enable, channels 8..15
    logic [7:0] frac_low_r;      // Base fraction bits 7..0
    logic [7:0] frac_mid_r;      // Base fraction bits 15..8
    logic [7:0] frac_high_r;     // Base fraction bits 19..16 in low nibble
    logic [7:0] int_counts_r;    // Integer count high nibble, auxiliary low
    logic [7:0] space_low_r;     // Spacing word low byte
    logic [7:0] space_high_r;    // Spacing word high byte
    logic [7:0] chan_sel_r;      // Channel select

    // Sequencer and outputs
    cfd_pkg::cfd_state_t state_r;
    cfd_pkg::cfd_state_t state_nxt;
    logic                 dirty_r;     // Settings changed since last load
    logic [5:0]           div_n_r;
    logic [1:0]           div_a_r;
    logic [FRAC_BITS-1:0] div_frac_r;
    logic                 upd_r;
    logic                 chan_en_r;

    // Write strobes, one per register
    wire logic wr_en_low     = reg_wr && (reg_addr == `CFD_ADDR_EN_LOW);
    wire logic wr_en_high    = reg_wr && (reg_addr == `CFD_ADDR_EN_HIGH);
    wire logic wr_frac_low   = reg_wr && (reg_addr == `CFD_ADDR_FRAC_LOW);
    wire logic wr_frac_mid   = reg_wr && (reg_addr == `CFD_ADDR_FRAC_MID);
    wire logic wr_frac_high  = reg_wr && (reg_addr == `CFD_ADDR_FRAC_HIGH);
    wire logic wr_int_counts = reg_wr && (reg_addr == `CFD_ADDR_INT_COUNTS);
    wire logic wr_space_low  = reg_wr && (reg_addr == `CFD_ADDR_SPACE_LOW);
    wire logic wr_space_high = reg_wr && (reg_addr == `CFD_ADDR_SPACE_HIGH);
    wire logic wr_chan_sel   = reg_wr && (reg_addr == `CFD_ADDR_CHAN_SEL);
    wire logic any_wr        = wr_en_low | wr_en_high | wr_frac_low | wr_frac_mid
                             | wr_frac_high | wr_int_counts | wr_space_low
                             | wr_space_high | wr_chan_sel;

    // Enable mask and selected channel
    wire logic [NUM_CHAN-1:0]  en_mask  = {en_high_r, en_low_r};                // R2
    wire logic [CHAN_BITS-1:0] chan_num = chan_sel_r[CHAN_BITS-1:0];            // R1 R3
    wire logic                 sel_on   = en_mask[chan_num];                    // R2

    // Base word: integer ratio N*4+A above the 20-bit fraction
    wire logic [3:0] base_n = int_counts_r[7:`CFD_N_LSB];                      // R12
    wire logic [3:0] base_a = int_counts_r[`CFD_N_LSB-1:0];                    // R12
    wire logic [`CFD_INT_BITS-1:0] base_int =
        `CFD_INT_BITS'({base_n, 2'b00}) + `CFD_INT_BITS'(base_a);              // R5
    wire logic [FRAC_BITS-1:0] base_frac =
        {frac_high_r[3:0], frac_mid_r, frac_low_r};                            // R6 R12
    // Whole ratio to the reference clock, integer part above the 20-bit fraction
    wire logic [WORD_BITS-1:0] base_word = {base_int, base_frac};              // R4
    // Spacing is a fraction of the reference, so it sits in fraction bits
    wire logic [15:0] space_word = {space_high_r, space_low_r};                // R7

    // Channel word, fractional overflow carries into the integer ratio
    logic [WORD_BITS-1:0] chan_word;
    cfd_mac #(
        .CHAN_BITS (CHAN_BITS),
        .WORD_BITS (WORD_BITS)
    ) u_mac (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .base_word  (base_word),
        .space_word (space_word),
        .chan_num   (chan_num),
        .sum_word   (chan_word)
    );                                                                          // R8 R11

    // Split integer ratio back into N and A with the fixed prescaler of four
    wire logic [`CFD_INT_BITS-1:0] chan_int = chan_word[WORD_BITS-1:FRAC_BITS];
    wire logic [5:0] new_n = chan_int[7:`CFD_PRESCALE_SHIFT];                  // R5
    wire logic [1:0] new_a = chan_int[`CFD_PRESCALE_SHIFT-1:0];                // R5

    // Read multiplexer; unmapped offsets read zero
    assign reg_rdata = (reg_addr == `CFD_ADDR_EN_LOW)     ? en_low_r     :
                       (reg_addr == `CFD_ADDR_EN_HIGH)    ? en_high_r    :
                       (reg_addr == `CFD_ADDR_FRAC_LOW)   ? frac_low_r   :
                       (reg_addr == `CFD_ADDR_FRAC_MID)   ? frac_mid_r   :
                       (reg_addr == `CFD_ADDR_FRAC_HIGH)  ? frac_high_r  :
                       (reg_addr == `CFD_ADDR_INT_COUNTS) ? int_counts_r :
                       (reg_addr == `CFD_ADDR_SPACE_LOW)  ? space_low_r  :
                       (reg_addr == `CFD_ADDR_SPACE_HIGH) ? space_high_r :
                       (reg_addr == `CFD_ADDR_CHAN_SEL)   ? chan_sel_r   :
                       8'h00;

    // Host register writes
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            en_low_r     <= `CFD_RST_EN_LOW;
            en_high_r    <= `CFD_RST_EN_HIGH;
            frac_low_r   <= `CFD_RST_ZERO;
            frac_mid_r   <= `CFD_RST_ZERO;
            frac_high_r  <= `CFD_RST_ZERO;
            int_counts_r <= `CFD_RST_ZERO;
            space_low_r  <= `CFD_RST_ZERO;
            space_high_r <= `CFD_RST_ZERO;
            chan_sel_r   <= `CFD_RST_ZERO;
        end
        else
        begin
            if (wr_en_low)     en_low_r     <= reg_wdata;
            if (wr_en_high)    en_high_r    <= reg_wdata;
            if (wr_frac_low)   frac_low_r   <= reg_wdata;
            if (wr_frac_mid)   frac_mid_r   <= reg_wdata;
            if (wr_frac_high)  frac_high_r  <= reg_wdata;
            if (wr_int_counts) int_counts_r <= reg_wdata;
            if (wr_space_low)  space_low_r  <= reg_wdata;
            if (wr_space_high) space_high_r <= reg_wdata;
            if (wr_chan_sel)   chan_sel_r   <= reg_wdata;
        end
    end

    // Next state: wait one cycle for the adder register, then load
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            cfd_pkg::CFD_IDLE: if (dirty_r && !any_wr) state_nxt = cfd_pkg::CFD_CALC;
            cfd_pkg::CFD_CALC: state_nxt = any_wr ? cfd_pkg::CFD_IDLE
                                                  : cfd_pkg::CFD_LOAD;
            cfd_pkg::CFD_LOAD: state_nxt = cfd_pkg::CFD_IDLE;
            default:           state_nxt = cfd_pkg::CFD_IDLE;
        endcase
    end

    // Sequencer; a write during calculation restarts it so no stale word loads
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= cfd_pkg::CFD_IDLE;
            dirty_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            // New write wins over the clear of the same cycle
            if (any_wr)
                dirty_r <= 1'b1;
            else if (state_r == cfd_pkg::CFD_CALC)
                dirty_r <= 1'b0;
        end
    end

    // Divider outputs; a disabled channel keeps the previous divider words
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_n_r    <= '0;
            div_a_r    <= '0;
            div_frac_r <= '0;
            upd_r      <= 1'b0;
            chan_en_r  <= 1'b0;
        end
        else
        begin
            upd_r <= 1'b0;
            if (state_r == cfd_pkg::CFD_LOAD)
            begin
                chan_en_r <= sel_on;                                            // R2
                if (sel_on)
                begin
                    div_n_r    <= new_n;                                        // R5
                    div_a_r    <= new_a;                                        // R5
                    div_frac_r <= chan_word[FRAC_BITS-1:0];                     // R6 R11
                    upd_r      <= 1'b1;
                end
            end
        end
    end

    assign div_n        = div_n_r;
    assign div_a        = div_a_r;
    assign div_frac     = div_frac_r;
    assign div_update   = upd_r;
    assign chan_enabled = chan_en_r;

    // Update only ever follows the load state
    a_update_after_load: assert property (@(posedge clk_sys) disable iff (!rst_b) // R11
        div_update |-> $past(state_r) == cfd_pkg::CFD_LOAD)
        else $error("Divider update without load");
    // An enabled channel load always updates next cycle
    a_enabled_loads: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
        (state_r == cfd_pkg::CFD_LOAD && sel_on) |=> div_update)
        else $error("Enabled channel not loaded");
    // A disabled channel never changes the divider
    a_disabled_holds: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
        (state_r == cfd_pkg::CFD_LOAD && !sel_on) |=> (!div_update && $stable(div_frac)))
        else $error("Disabled channel changed divider");
    // Integer ratio is N times four plus A
    a_ratio_split: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
        div_update |-> {div_n, div_a} == $past(chan_int))
        else $error("Integer split wrong");
    // Channel zero reproduces the base word exactly
    a_chan_zero: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
        (state_r == cfd_pkg::CFD_CALC && chan_num == 4'h0 && $stable(base_word))
        |-> chan_word == base_word)
        else $error("Channel zero differs from base");
    // Adjacent channels differ by exactly the spacing word
    a_spacing_step: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8 R11
        (state_r == cfd_pkg::CFD_CALC) |->
        chan_word == WORD_BITS'(base_word + chan_num * space_word))
        else $error("Channel offset wrong");
    // Settings change reaches the outputs within four cycles
    a_write_to_load: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
        (any_wr ##1 !any_wr [*3]) |-> ##[0:2] state_r == cfd_pkg::CFD_IDLE && !dirty_r)
        else $error("Write not applied in time");
    // Enabled flag follows the mask bit of the selected channel
    a_flag_tracks: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1 R2
        (state_r == cfd_pkg::CFD_LOAD) |=> chan_enabled == $past(sel_on))
        else $error("Enable flag wrong");
    // Fraction output is the low 20 bits of the channel word
    a_frac_field: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6 R7
        div_update |-> div_frac == $past(chan_word[FRAC_BITS-1:0]))
        else $error("Fraction field wrong");
endmodule

// [verilog/cfd_cfg.svh]
// Register offsets, field positions and reset values of the channel divider block
`ifndef CFD_CFG_SVH
`define CFD_CFG_SVH

// Register offsets in bank 0
`define CFD_ADDR_EN_LOW       7'h2e
`define CFD_ADDR_EN_HIGH      7'h2f
`define CFD_ADDR_FRAC_LOW     7'h48
`define CFD_ADDR_FRAC_MID     7'h49
`define CFD_ADDR_FRAC_HIGH    7'h4a
`define CFD_ADDR_INT_COUNTS   7'h4b
`define CFD_ADDR_SPACE_LOW    7'h4c
`define CFD_ADDR_SPACE_HIGH   7'h4d
`define CFD_ADDR_CHAN_SEL     7'h6b

// Reset values
`define CFD_RST_EN_LOW        8'hff
`define CFD_RST_EN_HIGH       8'hff
`define CFD_RST_ZERO          8'h00

// Field layout
`define CFD_FRAC_BITS         20
`define CFD_CHAN_BITS         4
`define CFD_NUM_CHAN          16
`define CFD_PRESCALE_SHIFT    2
`define CFD_INT_BITS          8
`define CFD_N_LSB             4
`define CFD_REF_MHZ           36

`endif

// [verilog/cfd_pkg.sv]
// Types shared by the channel divider block
package cfd_pkg;
    // Recompute sequence, one-hot
    typedef enum logic [2:0] {
        CFD_IDLE = 3'b001,
        CFD_CALC = 3'b010,
        CFD_LOAD = 3'b100
    } cfd_state_t;
endpackage

// [verilog/cfd_mac.sv]
// Channel offset multiply-accumulate: base plus channel times spacing
`timescale 1ns/1ps
`include "cfd_cfg.svh"
module cfd_mac #(
    parameter int CHAN_BITS = `CFD_CHAN_BITS,
    parameter int WORD_BITS = `CFD_FRAC_BITS + `CFD_INT_BITS
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    // Operands
    input  wire logic [WORD_BITS-1:0] base_word,
    input  wire logic [15:0]          space_word,
    input  wire logic [CHAN_BITS-1:0] chan_num,
    // Registered sum
    output logic      [WORD_BITS-1:0] sum_word
);
    // One partial product per channel-number bit
    logic [WORD_BITS-1:0] part [CHAN_BITS+1];

    assign part[0] = base_word;

    // Shift-add chain, no multiplier needed for a 4-bit factor
    genvar gi;
    generate
        for (gi = 0; gi < CHAN_BITS; gi++)
        begin : g_add
            wire logic [WORD_BITS-1:0] shifted;
            assign shifted = WORD_BITS'({{(WORD_BITS-16){1'b0}}, space_word} << gi);
            assign part[gi+1] = chan_num[gi] ? part[gi] + shifted : part[gi];
        end
    endgenerate

    // Result held in a register so the divider outputs stay flop-driven
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sum_word <= '0;
        end
        else
        begin
            sum_word <= part[CHAN_BITS];
        end
    end
endmodule

// [testbench/cfd_pll_model.sv]
// Far-side synthesizer model that latches each loaded divider ratio
`timescale 1ns/1ps
module cfd_pll_model (
    // Reference clock
    input  wire logic        clk_sys,
    // Divider words from the block
    input  wire logic [5:0]  div_n,
    input  wire logic [1:0]  div_a,
    input  wire logic [19:0] div_frac,
    input  wire logic        div_update,
    // Ratio to the 36 MHz reference, times 2^20
    output logic      [27:0] ratio_word
);
    // Prescaler of four folds N and A into one integer ratio
    always_ff @(posedge clk_sys)
    begin
        // Old ratio kept between loads, as the loop would
        if (div_update)
        begin
            ratio_word <= {div_n, div_a, div_frac};
        end
    end
endmodule

// [testbench/testbench.sv]
// Self-checking bench for the channel divider block
`timescale 1ns/1ps
module testbench;
    logic        clk_sys   = 1'b0;
    logic        rst_b     = 1'b0;
    logic [6:0]  reg_addr  = 7'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic [7:0]  reg_rdata;
    logic [5:0]  div_n;
    logic [1:0]  div_a;
    logic [19:0] div_frac;
    logic        div_update;
    logic        chan_enabled;
    logic [27:0] ratio_word;
    int          err_count = 0;
    int          checks    = 0;
    int          seed      = 32'h3b60;
    longint      exp_word  = 0;
    int          base_na, base_f, spc, npulse;
    logic [15:0] mask      = 16'hffff;
    logic [6:0]  ra [10]   = '{7'h2e, 7'h2f, 7'h48, 7'h49, 7'h4a, 7'h4b, 7'h4c,
                               7'h4d, 7'h6b, 7'h50};
    logic [7:0]  rv [10]   = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                               8'h00, 8'h00, 8'h00};

    // Free-running 100 MHz clock
    always #5 clk_sys = ~clk_sys;

    cfd_chan_div cfd_chan_div_i (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .div_n(div_n),
        .div_a(div_a), .div_frac(div_frac), .div_update(div_update), .chan_enabled(chan_enabled));
    cfd_pll_model cfd_pll_model_i (.clk_sys(clk_sys), .div_n(div_n), .div_a(div_a),
        .div_frac(div_frac), .div_update(div_update), .ratio_word(ratio_word));

    // Single comparison point
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task tally_and_finish;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One register write, strobe held for a single edge
    task wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
    endtask

    // Combinational read, looked at while the address holds
    task rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        #1;
        chk(32'(reg_rdata), 32'(e));
    endtask

    // Bounded wait for the load pulse; a miss ends the run
    task wait_upd;
        for (int i = 0; i < 12; i++)
        begin
            @(posedge clk_sys);
            #1;
            if (div_update === 1'b1)
                return;
        end
        // Missing pulse goes through the one comparison point, then the verdict
        chk(32'(div_update), 32'h0000_0001);
        tally_and_finish;
    endtask

    // Outputs and far-side ratio against the model word
    task check_out;
        chk(32'(div_n), 32'((exp_word >> 22) & 64'h3f));
        chk(32'(div_a), 32'((exp_word >> 20) & 64'h3));
        chk(32'(div_frac), 32'(exp_word & 64'hf_ffff));
        @(posedge clk_sys);
        #1;
        chk(32'(ratio_word), 32'(exp_word & 64'hfff_ffff));
    endtask

    // Base plus channel times spacing, carries into the counts
    function automatic longint model(input int ch);
        return ((longint'((base_na >> 4) * 4 + (base_na & 15))) << 20) + base_f + ch * spc;
    endfunction

    // Base word and spacing word through their byte registers
    task prog(input int f, input int na, input int sp);
        base_f = f & 32'h000f_ffff;
        base_na = na & 32'h0000_00ff;
        spc = sp & 32'h0000_ffff;
        wr(7'h48, 8'(base_f));
        wr(7'h49, 8'(base_f >> 8));
        wr(7'h4a, 8'(base_f >> 16));
        wr(7'h4b, 8'(base_na));
        wr(7'h4c, 8'(spc));
        wr(7'h4d, 8'(spc >> 8));
    endtask

    // Channel select; a masked channel must hold the old words
    task sel(input logic [7:0] v);
        wr(7'h6b, v);
        if (mask[v[3:0]])
        begin
            exp_word = model(int'(v[3:0]));
            wait_upd;
            chk(32'(chan_enabled), 32'h0000_0001);
            check_out;
        end
        else
        begin
            npulse = 0;
            repeat (10)
            begin
                @(posedge clk_sys);
                #1;
                npulse += (div_update === 1'b1);
            end
            chk(32'(npulse), 32'h0000_0000);
            chk(32'(chan_enabled), 32'h0000_0000);
            chk(32'({div_n, div_a, div_frac}), 32'(exp_word & 64'hfff_ffff));
        end
    endtask

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        // Automatic load of channel zero after reset
        wait_upd;
        check_out;
        foreach (ra[i]) rd(ra[i], rv[i]);
        // Example base with a 400 kHz step, all channels in the lock window
        prog(32'h000a_4444, 32'h0000_0061, 32'h0000_2d82);
        for (int c = 0; c < 16; c++) sel(8'(c));
        rd(7'h4a, 8'h0a);
        rd(7'h4b, 8'h61);
        rd(7'h4d, 8'h2d);
        // Upper select bits stored but not used
        sel(8'hf3);
        rd(7'h6b, 8'hf3);
        // Unmapped write leaves everything alone
        wr(7'h50, 8'h5a);
        rd(7'h50, 8'h00);
        rd(7'h48, 8'h44);
        repeat (6) @(posedge clk_sys);
        // Software disables channels instead of moving the base
        mask = 16'ha5c3;
        wr(7'h2e, 8'hc3);
        wr(7'h2f, 8'ha5);
        repeat (6) @(posedge clk_sys);
        for (int c = 0; c < 16; c++) sel(8'(c));
        rd(7'h2f, 8'ha5);
        mask = 16'hffff;
        wr(7'h2e, 8'hff);
        wr(7'h2f, 8'hff);
        // Random bases, spacings and channels
        repeat (8)
        begin
            prog($random(seed), $random(seed), $random(seed));
            sel(8'($random(seed)));
        end
        tally_and_finish;
    end
endmodule
